/* File: core/ctsb_core.sv */
// wishbone-reached execution unit for transfer, stack, io-bit, shift and flag-bit operations
// Overview of operation
// - pmem byte load copies byte at pointer, then increments pointer, 3 cycles, flags kept.
// - push writes source byte to stack, flags kept, 2 cycles.
// - pop loads destination from stack, flags kept, 2 cycles.
// - io bit raise sets chosen io bit, other bits and flags kept.
// - io bit lower clears chosen io bit, other bits and flags kept.
// - left shift moves bits up, zero into bit 0, updates z c n v.
// - right shift moves bits down, zero into bit 7, updates z c n v.
// - left rotate puts old carry in bit 0, bit 7 to carry.
// - right rotate puts old carry in bit 7, bit 0 to carry.
// - arithmetic right shift keeps bit 7, updates z c n v.
// - nibble exchange swaps halves, flags kept.
// - bit to transfer flag copies chosen source bit into t only.
// - transfer flag to bit copies t into chosen bit, flags kept.
// - signed-test clear sets s to zero, others untouched.
//
// Local design decisions: register access over Wishbone and the placing of the registers.
`timescale 1ns/100ps
`include "ctsb_regs.svh"
module ctsb_core
    import ctsb_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        sys_rst,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [3:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o
);
    logic [3:0]  opQ;
    logic [2:0]  bitSelQ;
    logic [7:0]  operandQ;
    logic [7:0]  resultQ;
    logic [7:0]  flagsQ;
    logic [15:0] pointerQ;
    logic [7:0]  ioDataQ;
    logic [7:0]  pmemByteQ;
    logic [7:0]  stackByteQ;
    logic        doneQ;
    logic [1:0]  cycCntQ;
    ctsb_state_e stateQ;
    logic        ackQ;
    logic        wbReq;
    logic        wrStb;
    logic        goReq;
    logic [7:0]  shiftRes;
    logic [7:0]  shiftFlags;
    logic        busy;

    // one-hot of a bit index, used by io and t-bit operations
    function automatic logic [7:0] bitMask(input logic [2:0] idx);
        bitMask = 8'h01 << idx;
    endfunction

    // cycles an operation occupies
    function automatic logic [1:0] opCycles(input logic [3:0] op);
        if (op == CTSB_OP_PMEM_LOAD) begin
            opCycles = 2'(`CTSB_CYC_PMEM);
        end else if (op == CTSB_OP_PUSH || op == CTSB_OP_POP) begin
            opCycles = 2'(`CTSB_CYC_STACK);
        end else begin
            opCycles = 2'(`CTSB_CYC_ONE);
        end
    endfunction

    ctsb_shift_unit shifter (
        .op       (ctsb_op_e'(opQ)),
        .operand  (operandQ),
        .flagsIn  (flagsQ),
        .result   (shiftRes),
        .flagsOut (shiftFlags)
    );

    // bus decode; ack one cycle after strobe, dropped the following cycle
    assign wbReq = wb_cyc_i && wb_stb_i && !ackQ;
    // writes land on the edge that sees ack high, while the master still holds the request
    assign wrStb = wb_cyc_i && wb_stb_i && ackQ && wb_we_i && wb_sel_i[0];
    assign busy  = (stateQ != CTSB_IDLE);
    assign goReq = wrStb && (wb_adr_i == `CTSB_ADR_CTRL) && wb_sel_i[1] &&
                   wb_dat_i[`CTSB_CTRL_GO] && !busy;
    assign wb_ack_o = ackQ;

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            ackQ <= 1'b0;
        end else begin
            ackQ <= wbReq;
        end
    end

    // read mux registered so data comes from flip-flops
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            wb_dat_o <= 32'h0000_0000;
        end else if (wbReq && !wb_we_i) begin
            unique case (wb_adr_i)
                `CTSB_ADR_CTRL:    wb_dat_o <= {25'h0, bitSelQ, opQ};
                `CTSB_ADR_OPERAND: wb_dat_o <= {24'h0, operandQ};
                `CTSB_ADR_STATUS:  wb_dat_o <= {30'h0, doneQ, busy};
                `CTSB_ADR_RESULT:  wb_dat_o <= {24'h0, resultQ};
                `CTSB_ADR_POINTER: wb_dat_o <= {16'h0, pointerQ};
                `CTSB_ADR_IODATA:  wb_dat_o <= {24'h0, ioDataQ};
                `CTSB_ADR_PMEM:    wb_dat_o <= {24'h0, pmemByteQ};
                `CTSB_ADR_STACK:   wb_dat_o <= {24'h0, stackByteQ};
                `CTSB_ADR_FLAGS:   wb_dat_o <= {24'h0, flagsQ};
                default:           wb_dat_o <= 32'h0000_0000;
            endcase
        end
    end

    // operation select and operand registers
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            opQ      <= 4'h0;
            bitSelQ  <= 3'h0;
            operandQ <= `CTSB_BYTE_RST;
        end else if (goReq) begin
            opQ     <= wb_dat_i[`CTSB_CTRL_OP_LSB +: 4];
            bitSelQ <= wb_dat_i[`CTSB_CTRL_BIT_LSB +: 3];
        end else if (wrStb && !busy && wb_adr_i == `CTSB_ADR_OPERAND) begin
            operandQ <= wb_dat_i[7:0];
        end
    end

    // sequencer: idle, execute, last cycle
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            stateQ  <= CTSB_IDLE;
            cycCntQ <= 2'h0;
        end else begin
            unique case (stateQ)
                CTSB_IDLE: begin
                    if (goReq) begin
                        cycCntQ <= opCycles(wb_dat_i[3:0]) - 2'h1;
                        stateQ  <= (opCycles(wb_dat_i[3:0]) == 2'h1) ? CTSB_LAST : CTSB_EXEC;
                    end
                end
                CTSB_EXEC: begin
                    cycCntQ <= cycCntQ - 2'h1;
                    if (cycCntQ == 2'h1) begin
                        stateQ <= CTSB_LAST;
                    end
                end
                CTSB_LAST: begin
                    stateQ <= CTSB_IDLE;
                end
                default: begin
                    stateQ <= CTSB_IDLE;
                end
            endcase
        end
    end

    // done is sticky until the next start; a finish wins over a simultaneous start
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            doneQ <= 1'b0;
        end else if (stateQ == CTSB_LAST) begin
            doneQ <= 1'b1;
        end else if (goReq) begin
            doneQ <= 1'b0;
        end
    end

    // datapath commit in the final cycle only, so a write while busy cannot tear it
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            resultQ    <= `CTSB_BYTE_RST;
            flagsQ     <= `CTSB_FLAGS_RST;
            pointerQ   <= `CTSB_PTR_RST;
            ioDataQ    <= `CTSB_BYTE_RST;
            pmemByteQ  <= `CTSB_BYTE_RST;
            stackByteQ <= `CTSB_BYTE_RST;
        end else if (stateQ == CTSB_LAST) begin
            unique case (ctsb_op_e'(opQ))
                CTSB_OP_PMEM_LOAD: begin
                    resultQ  <= pmemByteQ;
                    pointerQ <= pointerQ + 16'h0001;
                end
                CTSB_OP_PUSH:     stackByteQ <= operandQ;
                CTSB_OP_POP:      resultQ <= stackByteQ;
                CTSB_OP_IO_RAISE: ioDataQ <= ioDataQ | bitMask(bitSelQ);
                CTSB_OP_IO_LOWER: ioDataQ <= ioDataQ & ~bitMask(bitSelQ);
                CTSB_OP_TO_T:     flagsQ[`CTSB_FLAG_T] <= operandQ[bitSelQ];
                CTSB_OP_FROM_T: begin
                    resultQ <= flagsQ[`CTSB_FLAG_T] ? (operandQ | bitMask(bitSelQ))
                                                    : (operandQ & ~bitMask(bitSelQ));
                end
                CTSB_OP_CLR_S:    flagsQ[`CTSB_FLAG_S] <= 1'b0;
                CTSB_OP_LSL, CTSB_OP_LSR, CTSB_OP_ROL, CTSB_OP_ROR, CTSB_OP_ASR, CTSB_OP_SWAP: begin
                    resultQ <= shiftRes;
                    flagsQ  <= shiftFlags;
                end
                default: begin
                    resultQ <= resultQ;
                end
            endcase
        end else if (wrStb && !busy) begin
            unique case (wb_adr_i)
                `CTSB_ADR_POINTER: pointerQ   <= wb_dat_i[15:0];
                `CTSB_ADR_IODATA:  ioDataQ    <= wb_dat_i[7:0];
                `CTSB_ADR_PMEM:    pmemByteQ  <= wb_dat_i[7:0];
                `CTSB_ADR_STACK:   stackByteQ <= wb_dat_i[7:0];
                `CTSB_ADR_FLAGS:   flagsQ     <= wb_dat_i[7:0];
                default:           flagsQ     <= flagsQ;
            endcase
        end
    end

    // helper: opcode of the last op started
    logic [3:0] startOpQ;
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            startOpQ <= 4'h0;
        end else if (goReq) begin
            startOpQ <= wb_dat_i[3:0];
        end
    end

    chk_pmem_three_cycles: assert property (@(posedge clk) disable iff (sys_rst)
        goReq && wb_dat_i[3:0] == 4'h0 |=> stateQ == CTSB_EXEC ##1 stateQ == CTSB_EXEC ##1 stateQ == CTSB_LAST)
        else $error("pmem load not three cycles");
    chk_pmem_ptr_inc: assert property (@(posedge clk) disable iff (sys_rst)
        stateQ == CTSB_LAST && opQ == 4'h0 |=> pointerQ == $past(pointerQ) + 16'h0001 && resultQ == $past(pmemByteQ))
        else $error("pmem load pointer or data wrong");
    chk_push_two_cycles: assert property (@(posedge clk) disable iff (sys_rst)
        goReq && wb_dat_i[3:0] == 4'h1 |=> stateQ == CTSB_EXEC ##1 stateQ == CTSB_LAST ##1 stackByteQ == $past(operandQ) && $stable(flagsQ))
        else $error("push wrong");
    chk_pop_data: assert property (@(posedge clk) disable iff (sys_rst)
        stateQ == CTSB_LAST && opQ == 4'h2 |=> resultQ == $past(stackByteQ) && flagsQ == $past(flagsQ))
        else $error("pop wrong");
    chk_io_raise_bit: assert property (@(posedge clk) disable iff (sys_rst)
        stateQ == CTSB_LAST && opQ == 4'h3 |=> ioDataQ == ($past(ioDataQ) | (8'h01 << $past(bitSelQ))))
        else $error("io raise wrong");
    chk_io_lower_bit: assert property (@(posedge clk) disable iff (sys_rst)
        stateQ == CTSB_LAST && opQ == 4'h4 |=> ioDataQ == ($past(ioDataQ) & ~(8'h01 << $past(bitSelQ))))
        else $error("io lower wrong");
    chk_lsl_result: assert property (@(posedge clk) disable iff (sys_rst)
        stateQ == CTSB_LAST && opQ == 4'h5 |=> resultQ == {$past(operandQ[6:0]), 1'b0} && flagsQ[0] == $past(operandQ[7]))
        else $error("left shift wrong");
    chk_lsr_result: assert property (@(posedge clk) disable iff (sys_rst)
        stateQ == CTSB_LAST && opQ == 4'h6 |=> resultQ == {1'b0, $past(operandQ[7:1])} && flagsQ[0] == $past(operandQ[0]))
        else $error("right shift wrong");
    chk_rol_result: assert property (@(posedge clk) disable iff (sys_rst)
        stateQ == CTSB_LAST && opQ == 4'h7 |=> resultQ == {$past(operandQ[6:0]), $past(flagsQ[0])})
        else $error("left rotate wrong");
    chk_ror_result: assert property (@(posedge clk) disable iff (sys_rst)
        stateQ == CTSB_LAST && opQ == 4'h8 |=> resultQ == {$past(flagsQ[0]), $past(operandQ[7:1])})
        else $error("right rotate wrong");
    chk_asr_sign: assert property (@(posedge clk) disable iff (sys_rst)
        stateQ == CTSB_LAST && opQ == 4'h9 |=> resultQ[7] == $past(operandQ[7]) && resultQ[6:0] == $past(operandQ[7:1]))
        else $error("arith shift wrong");
    chk_swap_flags: assert property (@(posedge clk) disable iff (sys_rst)
        stateQ == CTSB_LAST && opQ == 4'ha |=> resultQ == {$past(operandQ[3:0]), $past(operandQ[7:4])} && $stable(flagsQ))
        else $error("swap wrong");
    chk_t_store: assert property (@(posedge clk) disable iff (sys_rst)
        stateQ == CTSB_LAST && opQ == 4'hb |=> flagsQ[6] == $past(operandQ[bitSelQ]) && flagsQ[5:0] == $past(flagsQ[5:0]))
        else $error("t store wrong");
    chk_t_load: assert property (@(posedge clk) disable iff (sys_rst)
        stateQ == CTSB_LAST && opQ == 4'hc |=> resultQ[$past(bitSelQ)] == $past(flagsQ[6]) && $stable(flagsQ))
        else $error("t load wrong");
    chk_s_clear: assert property (@(posedge clk) disable iff (sys_rst)
        stateQ == CTSB_LAST && opQ == 4'hd |=> !flagsQ[4] && flagsQ[3:0] == $past(flagsQ[3:0]))
        else $error("s clear wrong");
    chk_busy_blocks: assert property (@(posedge clk) disable iff (sys_rst)
        busy && wrStb |=> startOpQ == $past(startOpQ))
        else $error("start taken while busy");
endmodule

/* File: core/ctsb_regs.svh */
// offsets, field positions, reset values and cycle counts for the transfer/shift/bit unit
`ifndef CTSB_REGS_SVH
`define CTSB_REGS_SVH
`define CTSB_ADR_CTRL      4'h0
`define CTSB_ADR_OPERAND   4'h1
`define CTSB_ADR_STATUS    4'h2
`define CTSB_ADR_RESULT    4'h3
`define CTSB_ADR_POINTER   4'h4
`define CTSB_ADR_IODATA    4'h5
`define CTSB_ADR_PMEM      4'h6
`define CTSB_ADR_STACK     4'h7
`define CTSB_ADR_FLAGS     4'h8
`define CTSB_CTRL_GO       8
`define CTSB_CTRL_OP_LSB   0
`define CTSB_CTRL_BIT_LSB  4
`define CTSB_FLAG_C        0
`define CTSB_FLAG_Z        1
`define CTSB_FLAG_N        2
`define CTSB_FLAG_V        3
`define CTSB_FLAG_S        4
`define CTSB_FLAG_T        6
`define CTSB_STAT_BUSY     0
`define CTSB_STAT_DONE     1
`define CTSB_FLAGS_RST     8'h00
`define CTSB_BYTE_RST      8'h00
`define CTSB_PTR_RST       16'h0000
`define CTSB_CYC_PMEM      3
`define CTSB_CYC_STACK     2
`define CTSB_CYC_ONE       1
`endif

/* File: core/ctsb_pkg.sv */
// types for the transfer/shift/bit unit
package ctsb_pkg;
    typedef enum logic [3:0] {
        CTSB_OP_PMEM_LOAD  = 4'h0,
        CTSB_OP_PUSH       = 4'h1,
        CTSB_OP_POP        = 4'h2,
        CTSB_OP_IO_RAISE   = 4'h3,
        CTSB_OP_IO_LOWER   = 4'h4,
        CTSB_OP_LSL        = 4'h5,
        CTSB_OP_LSR        = 4'h6,
        CTSB_OP_ROL        = 4'h7,
        CTSB_OP_ROR        = 4'h8,
        CTSB_OP_ASR        = 4'h9,
        CTSB_OP_SWAP       = 4'ha,
        CTSB_OP_TO_T       = 4'hb,
        CTSB_OP_FROM_T     = 4'hc,
        CTSB_OP_CLR_S      = 4'hd
    } ctsb_op_e;
    typedef enum logic [1:0] {
        CTSB_IDLE  = 2'b00,
        CTSB_EXEC  = 2'b01,
        CTSB_LAST  = 2'b11
    } ctsb_state_e;
endpackage

/* File: core/ctsb_shift_unit.sv */
// combinational shift, rotate and nibble-exchange unit with flag results
`timescale 1ns/100ps
`include "ctsb_regs.svh"
module ctsb_shift_unit
    import ctsb_pkg::*;
(
    input  wire ctsb_op_e   op,
    input  wire logic [7:0] operand,
    input  wire logic [7:0] flagsIn,
    output logic      [7:0] result,
    output logic      [7:0] flagsOut
);
    logic carryOut;
    // result and carry per shift kind
    always_comb begin
        result   = operand;
        carryOut = flagsIn[`CTSB_FLAG_C];
        unique case (op)
            CTSB_OP_LSL: begin
                result   = {operand[6:0], 1'b0};
                carryOut = operand[7];
            end
            CTSB_OP_LSR: begin
                result   = {1'b0, operand[7:1]};
                carryOut = operand[0];
            end
            CTSB_OP_ROL: begin
                result   = {operand[6:0], flagsIn[`CTSB_FLAG_C]};
                carryOut = operand[7];
            end
            CTSB_OP_ROR: begin
                result   = {flagsIn[`CTSB_FLAG_C], operand[7:1]};
                carryOut = operand[0];
            end
            CTSB_OP_ASR: begin
                result   = {operand[7], operand[7:1]};
                carryOut = operand[0];
            end
            CTSB_OP_SWAP: begin
                result   = {operand[3:0], operand[7:4]};
            end
            default: begin
                result   = operand;
            end
        endcase
    end
    // flag update; v is n xor c, s is n xor v as the core defines them
    always_comb begin
        flagsOut = flagsIn;
        if (op == CTSB_OP_LSL || op == CTSB_OP_LSR || op == CTSB_OP_ROL ||
            op == CTSB_OP_ROR || op == CTSB_OP_ASR) begin
            flagsOut[`CTSB_FLAG_C] = carryOut;
            flagsOut[`CTSB_FLAG_Z] = (result == 8'h00);
            flagsOut[`CTSB_FLAG_N] = result[7];
            flagsOut[`CTSB_FLAG_V] = result[7] ^ carryOut;
            flagsOut[`CTSB_FLAG_S] = carryOut;
        end
    end
endmodule

/* File: bench/ctsb_far_model.sv */
// reference model of program memory byte, stack top, io register and status flag outcomes
`timescale 1ns/100ps
`include "ctsb_regs.svh"
module ctsb_far_model
    import ctsb_pkg::*;
;
    // expected state after one operation; resOk low means the result register is not judged
    function automatic void predict(input ctsb_op_e op, input logic [2:0] b, input logic [7:0] opd,
        input logic [7:0] fl, input logic [7:0] io, input logic [7:0] stk, input logic [7:0] pm,
        input logic [15:0] ptr, output logic resOk, output logic [7:0] res, output logic [7:0] flo,
        output logic [7:0] ioo, output logic [7:0] stko, output logic [15:0] ptro);
        logic c;
        logic sh;
        resOk = 1'b1;
        res = opd;
        flo = fl;
        ioo = io;
        stko = stk;
        ptro = ptr;
        sh = op inside {CTSB_OP_LSL, CTSB_OP_LSR, CTSB_OP_ROL, CTSB_OP_ROR, CTSB_OP_ASR};
        // left moves push bit 7 out, right moves push bit 0 out
        c = (op == CTSB_OP_LSL || op == CTSB_OP_ROL) ? opd[7] : opd[0];
        case (op)
            // byte at pointer, pointer wraps past the top
            CTSB_OP_PMEM_LOAD: res = pm;
            CTSB_OP_PUSH:      stko = opd;
            CTSB_OP_POP:       res = stk;
            CTSB_OP_IO_RAISE:  ioo[b] = 1'b1;
            CTSB_OP_IO_LOWER:  ioo[b] = 1'b0;
            CTSB_OP_LSL:       res = {opd[6:0], 1'b0};
            CTSB_OP_LSR:       res = {1'b0, opd[7:1]};
            CTSB_OP_ROL:       res = {opd[6:0], fl[`CTSB_FLAG_C]};
            CTSB_OP_ROR:       res = {fl[`CTSB_FLAG_C], opd[7:1]};
            CTSB_OP_ASR:       res = {opd[7], opd[7:1]};
            CTSB_OP_SWAP:      res = {opd[3:0], opd[7:4]};
            CTSB_OP_TO_T:      flo[`CTSB_FLAG_T] = opd[b];
            CTSB_OP_FROM_T:    res[b] = fl[`CTSB_FLAG_T];
            CTSB_OP_CLR_S:     flo[`CTSB_FLAG_S] = 1'b0;
            default:           resOk = 1'b0;
        endcase
        if (op == CTSB_OP_PMEM_LOAD)
            ptro = ptr + 16'h0001;
        if (op inside {CTSB_OP_PUSH, CTSB_OP_IO_RAISE, CTSB_OP_IO_LOWER, CTSB_OP_TO_T, CTSB_OP_CLR_S})
            resOk = 1'b0;
        // shared z c n v update, s follows n^v
        if (sh) begin
            flo[`CTSB_FLAG_C] = c;
            flo[`CTSB_FLAG_Z] = (res == 8'h00);
            flo[`CTSB_FLAG_N] = res[7];
            flo[`CTSB_FLAG_V] = res[7] ^ c;
            flo[`CTSB_FLAG_S] = c;
        end
    endfunction
endmodule

/* File: bench/testbench.sv */
// self-checking bench for the transfer, shift and bit unit
`timescale 1ns/100ps
`include "ctsb_regs.svh"
module testbench
    import ctsb_pkg::*;
;
    logic        clk;
    logic        sysRst;
    logic        wbCyc;
    logic        wbStb;
    logic        wbWe;
    logic [3:0]  wbAdr;
    logic [31:0] wbDatI;
    logic [31:0] wbDatO;
    logic        wbAck;
    logic [31:0] q;
    logic [7:0]  corner [4] = '{8'h00, 8'h80, 8'h01, 8'hff};
    int          n_mismatch;
    int          comparisons;

    ctsb_core dut_u (.clk(clk), .sys_rst(sysRst), .wb_cyc_i(wbCyc), .wb_stb_i(wbStb), .wb_we_i(wbWe),
        .wb_adr_i(wbAdr), .wb_sel_i(4'hf), .wb_dat_i(wbDatI), .wb_dat_o(wbDatO), .wb_ack_o(wbAck));
    ctsb_far_model far_u ();

    // 25 MHz clock
    always #20 clk = ~clk;

    task automatic summarize();
        if (n_mismatch == 0 && comparisons > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // one classic cycle; request held until the rising edge that samples ack high
    task automatic wbCycle(input logic w, input logic [3:0] a, input logic [31:0] d, output logic [31:0] r);
        int n;
        n = 0;
        wbCyc <= 1'b1;
        wbStb <= 1'b1;
        wbWe <= w;
        wbAdr <= a;
        wbDatI <= d;
        @(posedge clk);
        while (wbAck !== 1'b1 && n < 20) begin
            @(posedge clk);
            n++;
        end
        r = wbDatO;
        if (n >= 20) begin
            n_mismatch++;
            summarize();
        end
        wbCyc <= 1'b0;
        wbStb <= 1'b0;
        wbWe <= 1'b0;
        // one idle cycle between requests
        @(posedge clk);
    endtask

    task automatic wbWrite(input logic [3:0] a, input logic [31:0] d);
        logic [31:0] r;
        wbCycle(1'b1, a, d, r);
    endtask

    // load every operand, start, wait on busy, then judge status, result (when resOk), flags, io data, stack and pointer
    task automatic runOp(input ctsb_op_e op, input logic [2:0] b, input logic [7:0] opd, input logic [7:0] fl,
        input logic [7:0] io, input logic [7:0] stk, input logic [7:0] pm, input logic [15:0] ptr);
        logic        resOk;
        logic [7:0]  res;
        logic [7:0]  flo;
        logic [7:0]  ioo;
        logic [7:0]  stko;
        logic [15:0] ptro;
        int          n;
        far_u.predict(op, b, opd, fl, io, stk, pm, ptr, resOk, res, flo, ioo, stko, ptro);
        wbWrite(`CTSB_ADR_POINTER, {16'h0000, ptr});
        wbWrite(`CTSB_ADR_PMEM, {24'h000000, pm});
        wbWrite(`CTSB_ADR_OPERAND, {24'h000000, opd});
        wbWrite(`CTSB_ADR_FLAGS, {24'h000000, fl});
        wbWrite(`CTSB_ADR_IODATA, {24'h000000, io});
        wbWrite(`CTSB_ADR_STACK, {24'h000000, stk});
        wbWrite(`CTSB_ADR_CTRL, {23'h000000, 1'b1, 1'b0, b, op});
        n = 0;
        q = 32'h00000001;
        while (q[`CTSB_STAT_BUSY] !== 1'b0 && n < 20) begin
            wbCycle(1'b0, `CTSB_ADR_STATUS, 32'h00000000, q);
            n++;
        end
        check("status", q, 32'h00000002);
        if (resOk) begin
            wbCycle(1'b0, `CTSB_ADR_RESULT, 32'h0, q);
            check("result", q, {24'h0, res});
        end
        wbCycle(1'b0, `CTSB_ADR_FLAGS, 32'h0, q);
        check("flags", q, {24'h000000, flo});
        wbCycle(1'b0, `CTSB_ADR_IODATA, 32'h0, q);
        check("iodata", q, {24'h000000, ioo});
        wbCycle(1'b0, `CTSB_ADR_STACK, 32'h0, q);
        check("stack", q, {24'h000000, stko});
        wbCycle(1'b0, `CTSB_ADR_POINTER, 32'h0, q);
        check("pointer", q, {16'h0000, ptro});
    endtask

    // main sequence: reset values, every op with corner and random data, reset mid-op
    initial begin
        clk = 1'b0;
        sysRst = 1'b1;
        wbCyc = 1'b0;
        wbStb = 1'b0;
        wbWe = 1'b0;
        wbAdr = 4'h0;
        wbDatI = 32'h00000000;
        n_mismatch = 0;
        comparisons = 0;
        void'($urandom(74741));
        repeat (2) @(posedge clk);
        sysRst <= 1'b0;
        for (int a = 1; a <= 9; a++) begin
            wbCycle(1'b0, (a == 9) ? 4'hf : 4'(a), 32'h0, q);
            check("reset value", q, 32'h00000000);
        end
        for (int i = 0; i < 14; i++) begin
            for (int k = 0; k < 8; k++) begin
                runOp(ctsb_op_e'(4'(i)), 3'(k), (k < 4) ? corner[k] : 8'($urandom), 8'($urandom),
                    8'($urandom), 8'($urandom), 8'($urandom), (k == 0) ? 16'hffff : 16'($urandom));
            end
        end
        // reset lands while the three-cycle load is still running
        wbWrite(`CTSB_ADR_POINTER, 32'h00001234);
        wbWrite(`CTSB_ADR_CTRL, {23'h000000, 1'b1, 4'h0, CTSB_OP_PMEM_LOAD});
        sysRst <= 1'b1;
        repeat (2) @(posedge clk);
        sysRst <= 1'b0;
        wbCycle(1'b0, `CTSB_ADR_POINTER, 32'h0, q);
        check("pointer after reset", q, 32'h00000000);
        wbCycle(1'b0, `CTSB_ADR_STATUS, 32'h0, q);
        check("status after reset", q, 32'h00000000);
        summarize();
    end
endmodule
